// ===== hdl/sirq_bank.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "sirq_consts.svh"
// Functional notes
// [R1] Part code split across bytes 30h, 31h
// [R2] Low nibble of 31h is silicon stepping
// [R3] Configured flag clears on resets, sets on writes
// [R4] Host resets before new script when configured
// [R5] Host port strap latched at reset release
// [R6] Factory strap latched at reset or hard release
// [R7] Boot image strap latched from pins 2..0
// [R8] Pin toggle sets its change flag
// [R9] Change flag clears only on write one; the code also clears it while hard reset is held and on the reset pin
// [R10] Change flag requests only when enabled
// [R11] Live pin levels in bits 3..0
// [R12] Summary bits follow their source registers
// [R13] Global enable low blocks summary sources
// [R14] Global flag from enabled summaries or pins
// [R15] Global flag reaches pins via follow mode
// [R16] Boot finished clears on reset, sets at end
// [R17] Host avoids polling during boot
// [R18] Boot image may route boot flag to pin
// [R19] Follow pin picks status bit at 40h+sel; the code drives the pin low when that is 41h
// [R20] Code 0100 gives non-inverted status output
// [R21] Writes to read-only bits are ignored
module sirq_bank #(
  parameter logic [7:0] PART_CODE_UPPER = 8'h5a, // Arbitrary value
  parameter logic [3:0] PART_CODE_LOWER = 4'h3, // Arbitrary value
  parameter logic [3:0] SILICON_STEPPING = 4'h0 // First revision
) (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Reset pin, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error on unmapped
  input wire logic [1:0] host_port_pins, // Interface select pins
  input wire logic [3:0] gp_pin_in, // Pin levels, pin 3 is factory
  input wire logic [7:0] output_irq_summary_reg, // Output summary
  input wire logic [7:0] input_irq_summary_reg, // Input summary
  input wire logic [7:0] loop_irq_summary_reg, // Loop summary
  input wire logic boot_done_in, // Boot controller finished pulse
  input wire logic boot_write, // Boot controller register write
  input wire logic [15:0] pin_follow_cfg, // Per pin: mode nibble
  input wire logic [31:0] pin_follow_sel, // Per pin: reg5, bit3
  output logic [3:0] gp_pin_out, // Followed status levels
  output logic [3:0] gp_pin_oe // High while pin follows
);
  ////////////////////////////////////////////////////////////////
  sirq_pkg::sirq_state_t s_q, s_d;
  logic [7:0] rd_byte;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] wb;
  logic [3:0] w1c;

  // Byte address to register, returns the byte image
  function automatic logic [7:0] reg_image(
    input logic [7:0] a,
    input sirq_pkg::sirq_state_t s
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `SIRQ_IDX_PART_HIGH: v = PART_CODE_UPPER; // [R1]
      `SIRQ_IDX_PART_LOW: v = {PART_CODE_LOWER, SILICON_STEPPING}; // [R2]
      `SIRQ_IDX_CFG_STATE:
        v = {s.configured, 1'b0, s.host_strap, s.factory_strap,
             s.boot_strap};
      `SIRQ_IDX_PIN_STATE: v = {s.change_flag, s.pin_level}; // [R11]
      `SIRQ_IDX_IRQ_SUM:
        v = {2'b00, s.summary[2], s.summary[1], 1'b0, s.summary[0],
             s.gie, s.girq};
      `SIRQ_IDX_BOOT_EN: v = {s.boot_done, 3'b000, s.change_en};
      `SIRQ_IDX_RESET_CTL: v = {6'h00, s.hard_rst, s.soft_rst};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_image

  // Address fits the map
  function automatic logic mapped(input logic [11:0] a);
    // Word address carries the register index in bits 9..2
    return (a[11:10] == 2'b00) && (a[1:0] == 2'b00) &&
      (a[9:2] == `SIRQ_IDX_PART_HIGH || a[9:2] == `SIRQ_IDX_PART_LOW ||
       a[9:2] == `SIRQ_IDX_CFG_STATE || a[9:2] == `SIRQ_IDX_PIN_STATE ||
       a[9:2] == `SIRQ_IDX_IRQ_SUM || a[9:2] == `SIRQ_IDX_BOOT_EN ||
       a[9:2] == `SIRQ_IDX_RESET_CTL);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////
  // Byte index is word index; word address = 4 * index
  assign wr_acc = psel && penable && pwrite && !s_q.pready;
  assign rd_acc = psel && penable && !pwrite && !s_q.pready;
  assign wb = pstrb[0] ? pwdata[7:0] : 8'h00;

  // Next-state logic for the bank, apart from the pin enable flops
  always_comb
  begin
    logic [7:0] waddr;
    logic [3:0] toggles;
    logic [3:0] lvl;
    logic src;
    waddr = paddr[9:2];
    toggles = 4'h0;
    lvl = 4'h0;
    src = 1'b0;
    rd_byte = reg_image(waddr, s_q);
    w1c = 4'h0;
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    // Slave answers one cycle into the access phase
    if (psel && penable && !s_q.pready)
    begin
      s_d.pready = 1'b1;
      s_d.pslverr = !mapped(paddr);
      s_d.prdata = (rd_acc && mapped(paddr)) ? {24'h0, rd_byte} : 32'h0;
    end
    // Self-clearing soft reset pulse
    s_d.soft_rst = 1'b0;
    // Live pins and edge detection
    s_d.pin_level = gp_pin_in; // [R11]
    s_d.pin_prev = s_q.pin_level;
    toggles = s_q.pin_level ^ s_q.pin_prev; // [R8]
    if (wr_acc && mapped(paddr) && pstrb[0])
    begin
      s_d.configured = 1'b1; // [R3]
      case (waddr)
        `SIRQ_IDX_PIN_STATE: w1c = wb[7:4]; // [R9]
        `SIRQ_IDX_IRQ_SUM: s_d.gie = wb[`SIRQ_GIE_BIT];
        `SIRQ_IDX_BOOT_EN: s_d.change_en = wb[3:0];
        `SIRQ_IDX_RESET_CTL:
        begin
          s_d.hard_rst = wb[`SIRQ_HARD_BIT];
          s_d.soft_rst = wb[`SIRQ_SOFT_BIT];
        end
        default: s_d.configured = 1'b1; // Read-only bytes ignored [R21]
      endcase
    end
    if (boot_write)
      s_d.configured = 1'b1; // [R3]
    // Toggle set wins over a same-cycle write-one clear
    s_d.change_flag = (s_q.change_flag & ~w1c) | toggles; // [R8] [R9]
    // Summaries from source registers
    s_d.summary[2] = |output_irq_summary_reg; // [R12]
    s_d.summary[1] = |input_irq_summary_reg; // [R12]
    s_d.summary[0] = |loop_irq_summary_reg; // [R12]
    // Global flag: gated summaries plus enabled pin flags
    s_d.girq = (s_q.gie && |s_q.summary) || // [R13] [R14]
               |(s_q.change_flag & s_q.change_en); // [R10] [R14]
    if (boot_done_in)
      s_d.boot_done = 1'b1; // [R16]
    // Straps caught once after reset release
    if (!s_q.rst_seen)
    begin
      s_d.rst_seen = 1'b1;
      s_d.host_strap = host_port_pins; // [R5]
      s_d.factory_strap = gp_pin_in[3]; // [R6]
      s_d.boot_strap = gp_pin_in[2:0]; // [R7]
    end
    // Hard reset held: clear state; release recaptures pin straps
    s_d.hard_prev = s_q.hard_rst;
    if (s_q.hard_rst)
    begin
      s_d.configured = 1'b0; // [R3]
      s_d.boot_done = 1'b0; // [R16]
      s_d.change_flag = 4'h0;
      s_d.change_en = 4'h0;
      s_d.gie = 1'b0;
    end
    else if (s_q.hard_prev)
    begin
      s_d.factory_strap = gp_pin_in[3]; // [R6]
      s_d.boot_strap = gp_pin_in[2:0]; // [R7]
    end
    if (s_q.soft_rst)
      s_d.configured = 1'b0; // [R3]
    // Status-follow pins
    for (int i = 0; i < 4; i++)
    begin
      logic [7:0] ra;
      logic [7:0] img;
      ra = `SIRQ_FOLLOW_BASE + {3'b000, pin_follow_sel[i*8+3 +: 5]};
      img = reg_image(ra, s_q);
      // Pin state byte cannot be followed; drives low instead
      src = (ra == `SIRQ_IDX_PIN_STATE) ? 1'b0 :
            img[pin_follow_sel[i*8 +: 3]]; // [R19]
      lvl[i] = src;
      s_d.pin_out[i] = (pin_follow_cfg[i*4 +: 4] ==
                        `SIRQ_PIN_MODE_FOLLOW) ? lvl[i] : 1'b0; // [R20] [R15]
    end
    if (!clk_en)
      s_d = s_q;
  end

  // State register; reset pin clears everything
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0; // [R3] [R16]
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign gp_pin_out = s_q.pin_out;

  // Enable registers the follow-mode decode of pin_follow_cfg to keep the output registered
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_oe
      logic oe_q;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          oe_q <= 1'b0;
        else if (clk_en)
          oe_q <= (pin_follow_cfg[g*4 +: 4] == `SIRQ_PIN_MODE_FOLLOW);
      end
      assign gp_pin_oe[g] = oe_q;
    end
  endgenerate
endmodule : sirq_bank

// ===== hdl/sirq_consts.svh
`ifndef SIRQ_CONSTS_SVH
`define SIRQ_CONSTS_SVH
// Byte offsets of the bank (printed offsets are not all multiples of four)
`define SIRQ_IDX_PART_HIGH 8'h30
`define SIRQ_IDX_PART_LOW 8'h31
`define SIRQ_IDX_CFG_STATE 8'h40
`define SIRQ_IDX_PIN_STATE 8'h41
`define SIRQ_IDX_IRQ_SUM 8'h42
`define SIRQ_IDX_BOOT_EN 8'h43
// Own control register: reset bits
`define SIRQ_IDX_RESET_CTL 8'h50
// Field positions
`define SIRQ_CONFIGURED_FLAG_BIT 7
`define SIRQ_OC_BIT 5
`define SIRQ_IC_BIT 4
`define SIRQ_LOOP_BIT 2
`define SIRQ_GIE_BIT 1
`define SIRQ_GIRQ_BIT 0
`define SIRQ_BOOT_BIT 7
`define SIRQ_SOFT_BIT 0
`define SIRQ_HARD_BIT 1
// Pin follow mode code
`define SIRQ_PIN_MODE_FOLLOW 4'h4
`define SIRQ_FOLLOW_BASE 8'h40
// Reset values
`define SIRQ_IRQ_SUM_RST 8'h00
`endif

// ===== hdl/sirq_pkg.sv
package sirq_pkg;
  // Register bus phase
  typedef enum logic [1:0] {
    SIRQ_IDLE,
    SIRQ_ACCESS
  } sirq_phase_t;

  // State of the bank, apart from the pin enable flops
  typedef struct packed {
    sirq_phase_t phase;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic configured;
    logic [1:0] host_strap;
    logic factory_strap;
    logic [2:0] boot_strap;
    logic [3:0] pin_prev;
    logic [3:0] pin_level;
    logic [3:0] change_flag;
    logic [3:0] change_en;
    logic gie;
    logic [2:0] summary;
    logic girq;
    logic boot_done;
    logic hard_rst;
    logic hard_prev;
    logic soft_rst;
    logic rst_seen;
    logic [3:0] pin_out;
  } sirq_state_t;
endpackage : sirq_pkg

// ===== tb/sirq_bank_sva.sv
`timescale 1ns/1ps
module sirq_bank_sva (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic clk_en, // Enable
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [31:0] prdata, // Read data
  input wire logic [15:0] pin_follow_cfg, // Pin modes
  input wire logic [3:0] gp_pin_oe // Pin enables
);
  // Which pins sit in follow mode
  wire [3:0] fol = {pin_follow_cfg[15:12] == 4'h4,
    pin_follow_cfg[11:8] == 4'h4, pin_follow_cfg[7:4] == 4'h4,
    pin_follow_cfg[3:0] == 4'h4};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////
  // Bus answer: one wait state, one-cycle pulse, lowest byte lane only
  ready_one_wait_a: assert property (psel && penable && !pready && clk_en
    |=> pready) else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  clk_gate_a: assert property (pready |-> $past(clk_en))
    else $error("ready while frozen");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_zero_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error with data");
  byte_lane_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper lanes set");
  // Output enable is a registered copy of the follow decode
  pin_oe_a: assert property (clk_en |=> gp_pin_oe == $past(fol))
    else $error("pin enable wrong");
endmodule : sirq_bank_sva
bind sirq_bank sirq_bank_sva sirq_bank_sva_i (.pclk, .presetn, .clk_en,
  .psel, .penable, .pready, .pslverr, .prdata, .pin_follow_cfg, .gp_pin_oe);

// ===== tb/sirq_bank_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module sirq_bank_tb;
  localparam logic [7:0] UP = 8'h6c; // Arbitrary value
  localparam logic [3:0] LO = 4'h2; // Arbitrary value
  localparam logic [3:0] STEP = 4'h0; // First revision
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, pwrite = 1'b0;
  logic psel = 1'b0, penable = 1'b0, boot_done_in = 1'b0;
  logic boot_write = 1'b0, pready, pslverr, errq;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdq, pin_follow_sel = 32'h0;
  logic [3:0] pstrb = 4'hf, gp_pin_in = 4'h5, gp_pin_out, gp_pin_oe;
  logic [1:0] host_port_pins = 2'h2;
  logic [7:0] oc = 8'h0, ic = 8'h0, lp = 8'h0;
  logic [15:0] pin_follow_cfg = 16'h0;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  sirq_bank #(.PART_CODE_UPPER(UP), .PART_CODE_LOWER(LO),
    .SILICON_STEPPING(STEP)) sirq_bank_i (.pclk, .presetn, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .host_port_pins, .gp_pin_in, .output_irq_summary_reg(oc),
    .input_irq_summary_reg(ic), .loop_irq_summary_reg(lp), .boot_done_in,
    .boot_write, .pin_follow_cfg, .pin_follow_sel, .gp_pin_out, .gp_pin_oe);
  // Clock and hang guard
  always #25 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////
  // One APB transfer; a spare edge first so strobes never collide
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdq = prdata; errq = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer
  task rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    xfer(1'b0, a, 8'h0);
    `CHK("read", e, rdq[7:0] & m)
  endtask : rd
  // One-cycle pulse: 1 on boot finished, 0 on boot write
  task pulse(input logic which);
    if (which)
      boot_done_in <= 1'b1;
    else
      boot_write <= 1'b1;
    @(posedge pclk);
    boot_done_in <= 1'b0;
    boot_write <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  //////////////////////////////////////////////////////////////////////
  // Identity bytes, straps, configured flag and read-only writes
  task t_cfg;
    rd(12'h0c0, UP, 8'hff);
    rd(12'h0c4, {LO, STEP}, 8'hff);
    rd(12'h100, 8'h25, 8'hff);
    pulse(1'b0);
    rd(12'h100, 8'ha5, 8'hff);
    xfer(1'b1, 12'h0c0, 8'hff);
    rd(12'h0c0, UP, 8'hff);
    xfer(1'b1, 12'h140, 8'h01);
    rd(12'h100, 8'h25, 8'hff);
    xfer(1'b1, 12'h140, 8'h02);
    gp_pin_in <= 4'ha;
    xfer(1'b1, 12'h140, 8'h00);
    rd(12'h100, 8'h2a, 8'hff);
    xfer(1'b0, 12'h200, 8'h0);
    `CHK("unmapped", 1'b1, errq)
  endtask : t_cfg
  // Change flags: toggle, write-zero keeps, write-one clears
  task t_pins;
    xfer(1'b1, 12'h104, 8'hf0);
    rd(12'h104, 8'h0a, 8'hff);
    gp_pin_in <= 4'hb;
    repeat (4) @(posedge pclk);
    rd(12'h104, 8'h1b, 8'hff);
    xfer(1'b1, 12'h104, 8'h20);
    rd(12'h104, 8'h1b, 8'hff);
    xfer(1'b1, 12'h104, 8'h10);
    rd(12'h104, 8'h0b, 8'hff);
  endtask : t_pins
  // Pin change and summary sources into the global flag
  task t_irq;
    xfer(1'b1, 12'h108, 8'h02);
    xfer(1'b1, 12'h10c, 8'h01);
    gp_pin_in <= 4'ha;
    repeat (4) @(posedge pclk);
    rd(12'h108, 8'h03, 8'hff);
    rd(12'h10c, 8'h01, 8'hff);
    xfer(1'b1, 12'h10c, 8'h00);
    rd(12'h108, 8'h02, 8'hff);
    xfer(1'b1, 12'h108, 8'h00);
    oc <= 8'h80; ic <= 8'h01; lp <= 8'h02;
    repeat (4) @(posedge pclk);
    rd(12'h108, 8'h34, 8'hff);
    xfer(1'b1, 12'h108, 8'h02);
    rd(12'h108, 8'h37, 8'hff);
    pin_follow_cfg <= 16'h0004; pin_follow_sel <= 32'h10;
    repeat (3) @(posedge pclk);
    `CHK("pin0", 2'b11, {gp_pin_oe[0], gp_pin_out[0]})
    oc <= 8'h0; ic <= 8'h0; lp <= 8'h0;
    repeat (4) @(posedge pclk);
    `CHK("pin0", 2'b10, {gp_pin_oe[0], gp_pin_out[0]})
  endtask : t_irq
  // Boot finished drives a following pin; reset pin clears it
  task t_boot;
    pin_follow_sel <= 32'h1f;
    pulse(1'b1);
    rd(12'h10c, 8'h80, 8'hff);
    `CHK("pin0", 1'b1, gp_pin_out[0])
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h10c, 8'h00, 8'hff);
    rd(12'h108, 8'h00, 8'hff);
    rd(12'h100, 8'h2a, 8'hff);
  endtask : t_boot
  task summarize;
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // Reset, then the scenarios in turn
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_cfg();
    t_pins();
    t_irq();
    t_boot();
    summarize();
  end
endmodule : sirq_bank_tb
